/* core/srcr_pkg.sv */
// constants and types for the serial report command responder
package srcr_pkg;

   // ------------------------------------------------------------
   // characters
   // ------------------------------------------------------------
   localparam logic [7:0] CHAR_CR = 8'h0D;
   localparam logic [7:0] CHAR_STX = 8'h02;
   localparam logic [7:0] CHAR_ETX = 8'h03;
   localparam logic [7:0] CHAR_SPACE = 8'h20;
   localparam logic [7:0] CHAR_NUL = 8'h00;

   // ------------------------------------------------------------
   // command words and reply header
   // ------------------------------------------------------------
   localparam logic [31:0] CLEAR_RECEIVE_CMD = 32'h52534554;
   localparam logic [31:0] SEND_REPORT_CMD = 32'h534E4441;
   localparam logic [31:0] SEND_ALT_REPORT_CMD = 32'h534E4446;
   localparam logic [2:0] CMD_LEN = 3'h4;
   localparam logic [2:0] RX_COUNT_MAX = 3'h5;
   localparam logic [39:0] REPORT_REPLY_CODE = 40'h4D49534341;
   localparam logic [23:0] BYTE_COUNT_TEXT = 24'h373036;
   localparam logic [15:0] FIELD_COUNT_TEXT = 16'h3937;
   localparam logic [87:0] HEAD_TEXT = {REPORT_REPLY_CODE, BYTE_COUNT_TEXT, FIELD_COUNT_TEXT, CHAR_STX};
   localparam logic [3:0] HEAD_LEN = 4'hB;

   // ------------------------------------------------------------
   // field layout
   // ------------------------------------------------------------
   localparam logic [6:0] FIRST_FIELD = 7'h05;
   localparam logic [6:0] LAST_FIELD = 7'h63;
   localparam logic [6:0] TIME_FIELD = 7'h05;
   localparam logic [6:0] UNIT_ID_FIELD = 7'h06;
   localparam logic [6:0] DATE_FIELD = 7'h08;
   localparam logic [6:0] MODE_FIELD = 7'h09;
   localparam logic [6:0] SETTING_A_FIRST = 7'h0A;
   localparam logic [6:0] SETTING_A_LAST = 7'h10;
   localparam logic [6:0] SETTING_B_FIRST = 7'h15;
   localparam logic [6:0] SETTING_B_LAST = 7'h1A;
   localparam logic [6:0] FLOW_PATTERN_FIELD = 7'h1B;
   localparam logic [6:0] FULL_OXYGEN_FIELD = 7'h1E;
   localparam logic [6:0] MONITOR_A_FIRST = 7'h22;
   localparam logic [6:0] MONITOR_A_LAST = 7'h2A;
   localparam logic [6:0] MONITOR_B_FIRST = 7'h2D;
   localparam logic [6:0] MONITOR_B_LAST = 7'h2E;
   localparam logic [4:0] FIELD_WIDTH = 5'h06;
   localparam logic [4:0] UNIT_ID_WIDTH = 5'h12;
   localparam logic [4:0] DATE_WIDTH = 5'h0C;
   localparam int TEXT_BITS = 48;
   localparam int UNIT_ID_BITS = 144;
   localparam int DATE_BITS = 96;
   localparam int NUM_SETTING = 13;
   localparam int NUM_MONITOR = 11;
   localparam int FIFO_DEPTH = 8;
   localparam int FIFO_WIDTH = 8;

   // ------------------------------------------------------------
   // field tokens, six characters each
   // ------------------------------------------------------------
   localparam logic [47:0] TOKEN_ASSIST = 48'h434D56202020;
   localparam logic [47:0] TOKEN_SYNC = 48'h53494D562020;
   localparam logic [47:0] TOKEN_CONTINUOUS = 48'h435041502020;
   localparam logic [47:0] TOKEN_TWO_LEVEL = 48'h42494C45564C;
   localparam logic [47:0] TOKEN_SQUARE = 48'h535155415245;
   localparam logic [47:0] TOKEN_RAMP = 48'h52414D502020;
   localparam logic [47:0] TOKEN_ON = 48'h4F4E20202020;
   localparam logic [47:0] TOKEN_OFF = 48'h4F4646202020;
   localparam logic [47:0] TOKEN_UNUSED = 48'h4E4120202020;

   // ------------------------------------------------------------
   // types
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      assist_control_mode,
      sync_intermittent_mode,
      continuous_pressure_mode,
      two_level_pressure_mode
   } srcr_mode_type;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_HEAD,
      ST_FIELD,
      ST_ETX,
      ST_CR
   } srcr_state_type;

endpackage

/* core/srcr_fifo.sv */
// byte fifo between the report generator and the serial transmitter
`timescale 1ns/1ps
module srcr_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input wire logic mclk,
   input wire logic reset,
   input wire logic [WIDTH-1:0] inData,
   input wire logic inValid,
   output logic inReady,
   output logic [WIDTH-1:0] outData,
   output logic outValid,
   input wire logic outReady
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW:0] wrPtr;
      logic [AW:0] rdPtr;
   } srcr_fifo_state_type;

   srcr_fifo_state_type state;
   srcr_fifo_state_type next_state;
   logic fullFlag;
   logic emptyFlag;

   // ------------------------------------------------------------
   // flags
   // ------------------------------------------------------------
   assign emptyFlag = (state.wrPtr == state.rdPtr);
   assign fullFlag = (state.wrPtr[AW] != state.rdPtr[AW]) && (state.wrPtr[AW-1:0] == state.rdPtr[AW-1:0]);
   assign inReady = !fullFlag;
   assign outValid = !emptyFlag;
   assign outData = state.mem[state.rdPtr[AW-1:0]];

   // ------------------------------------------------------------
   // pointers and storage
   // ------------------------------------------------------------
   always_comb begin
      next_state = state;
      if (inValid && !fullFlag) begin
         next_state.mem[state.wrPtr[AW-1:0]] = inData;
         next_state.wrPtr = state.wrPtr + 1'b1;
      end
      if (outReady && !emptyFlag) begin
         next_state.rdPtr = state.rdPtr + 1'b1;
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end
endmodule

/* core/srcr_responder.sv */
// serial command interpreter and fixed-format report generator
`timescale 1ns/1ps
// Summary of operation
// [R1] a command is acted on only when a carriage return arrives
// [R2] clear command empties the receive buffer and sends no reply
// [R3] host sends exactly four upper-case letters then carriage return
// [R4] report command sends reply code, then settings and monitored values
// [R5] reply code is exactly five characters
// [R6] three-digit byte count 706 follows the reply code
// [R7] two-digit field count 97 follows the byte count
// [R8] start byte 02 hex follows both counts, before any field
// [R9] field 5 carries time as six characters
// [R10] field 6 carries the eighteen-character unit identifier
// [R11] field 8 carries the date as twelve characters
// [R12] field 9 carries one of four mode tokens, six characters
// [R13] short fields are padded with spaces to full width
// [R14] unsupported fields send the unused marker, six characters
// [R15] setting fields 10 to 26 are six-character text each
// [R16] field 27 reports square or ramp flow pattern
// [R17] field 30 reports full-oxygen state as on or off
// [R18] monitored fields 34 to 46 are six-character text in order
// [R19] field 41 gives expiratory part of ratio, inspiratory part one
// [R20] fields go out in ascending order with no separators
// [R21] report ends with end byte then carriage return
// [R22] unknown command words are dropped with no reply
module srcr_responder
   import srcr_pkg::*;
(
   input wire logic mclk,
   input wire logic reset,
   input wire logic [7:0] rxData,
   input wire logic rxValid,
   output logic [7:0] txData,
   output logic txValid,
   input wire logic txReady,
   input wire logic [TEXT_BITS-1:0] timeText,
   input wire logic [UNIT_ID_BITS-1:0] unitIdText,
   input wire logic [DATE_BITS-1:0] dateText,
   input wire logic [1:0] ventMode,
   input wire logic flowRamp,
   input wire logic fullOxygenOn,
   input wire logic [NUM_SETTING*TEXT_BITS-1:0] settingText,
   input wire logic [NUM_MONITOR*TEXT_BITS-1:0] monitorText,
   output logic busy,
   output logic clearSeen,
   output logic unknownSeen
);

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef struct packed {
      srcr_state_type phase;
      logic [3:0] headIdx;
      logic [6:0] fieldNum;
      logic [4:0] charIdx;
      logic [31:0] rxWord;
      logic [2:0] rxCount;
      logic reportPending;
      logic clearSeen;
      logic unknownSeen;
   } srcr_core_type;

   srcr_core_type core;
   srcr_core_type next_core;
   logic [7:0] genByte;
   logic genValid;
   logic genReady;
   logic [UNIT_ID_BITS-1:0] fieldText;
   logic [4:0] fieldWidth;
   logic [7:0] fieldChar;
   logic [NUM_SETTING-1:0][TEXT_BITS-1:0] settingArr;
   logic [NUM_MONITOR-1:0][TEXT_BITS-1:0] monitorArr;

   // ------------------------------------------------------------
   // field value arrays
   // ------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < NUM_SETTING; gi++) begin : gSetting
         assign settingArr[gi] = settingText[gi*TEXT_BITS +: TEXT_BITS];
      end
      for (gi = 0; gi < NUM_MONITOR; gi++) begin : gMonitor
         assign monitorArr[gi] = monitorText[gi*TEXT_BITS +: TEXT_BITS];
      end
   endgenerate

   // ------------------------------------------------------------
   // field text selection, left justified
   // ------------------------------------------------------------
   always_comb begin
      fieldText = {TOKEN_UNUSED, 96'h0}; // [R14]
      fieldWidth = FIELD_WIDTH;
      if (core.fieldNum == TIME_FIELD) begin
         fieldText = {timeText, 96'h0}; // [R9]
      end else if (core.fieldNum == UNIT_ID_FIELD) begin
         fieldText = unitIdText; // [R10]
         fieldWidth = UNIT_ID_WIDTH;
      end else if (core.fieldNum == DATE_FIELD) begin
         fieldText = {dateText, 48'h0}; // [R11]
         fieldWidth = DATE_WIDTH;
      end else if (core.fieldNum == MODE_FIELD) begin
         case (srcr_mode_type'(ventMode)) // [R12]
            assist_control_mode: fieldText = {TOKEN_ASSIST, 96'h0};
            sync_intermittent_mode: fieldText = {TOKEN_SYNC, 96'h0};
            continuous_pressure_mode: fieldText = {TOKEN_CONTINUOUS, 96'h0};
            two_level_pressure_mode: fieldText = {TOKEN_TWO_LEVEL, 96'h0};
            default: fieldText = {TOKEN_UNUSED, 96'h0};
         endcase
      end else if (core.fieldNum >= SETTING_A_FIRST && core.fieldNum <= SETTING_A_LAST) begin
         fieldText = {settingArr[4'(core.fieldNum - SETTING_A_FIRST)], 96'h0}; // [R15]
      end else if (core.fieldNum >= SETTING_B_FIRST && core.fieldNum <= SETTING_B_LAST) begin
         fieldText = {settingArr[4'(core.fieldNum - SETTING_B_FIRST + 7'h07)], 96'h0}; // [R15]
      end else if (core.fieldNum == FLOW_PATTERN_FIELD) begin
         fieldText = {(flowRamp ? TOKEN_RAMP : TOKEN_SQUARE), 96'h0}; // [R16]
      end else if (core.fieldNum == FULL_OXYGEN_FIELD) begin
         fieldText = {(fullOxygenOn ? TOKEN_ON : TOKEN_OFF), 96'h0}; // [R17]
      end else if (core.fieldNum >= MONITOR_A_FIRST && core.fieldNum <= MONITOR_A_LAST) begin
         // field 41 text holds the expiratory part with inspiratory taken as one
         fieldText = {monitorArr[4'(core.fieldNum - MONITOR_A_FIRST)], 96'h0}; // [R18] [R19]
      end else if (core.fieldNum >= MONITOR_B_FIRST && core.fieldNum <= MONITOR_B_LAST) begin
         fieldText = {monitorArr[4'(core.fieldNum - MONITOR_B_FIRST + 7'h09)], 96'h0}; // [R18]
      end
   end

   // ------------------------------------------------------------
   // character pick with space padding
   // ------------------------------------------------------------
   always_comb begin
      fieldChar = fieldText[UNIT_ID_BITS-1 - 8*core.charIdx -: 8];
      if (fieldChar == CHAR_NUL) begin
         fieldChar = CHAR_SPACE; // [R13]
      end
   end

   // ------------------------------------------------------------
   // byte source for the transmit fifo
   // ------------------------------------------------------------
   always_comb begin
      genValid = 1'b1;
      genByte = CHAR_SPACE;
      case (core.phase)
         ST_IDLE: begin
            genValid = 1'b0;
         end
         ST_HEAD: begin
            genByte = HEAD_TEXT[87 - 8*core.headIdx -: 8]; // [R5] [R6] [R7] [R8]
         end
         ST_FIELD: begin
            genByte = fieldChar;
         end
         ST_ETX: begin
            genByte = CHAR_ETX; // [R21]
         end
         ST_CR: begin
            genByte = CHAR_CR; // [R21]
         end
         default: begin
            genValid = 1'b0;
         end
      endcase
   end

   // ------------------------------------------------------------
   // receive and sequencing
   // ------------------------------------------------------------
   always_comb begin
      next_core = core;
      next_core.clearSeen = 1'b0;
      next_core.unknownSeen = 1'b0;

      // report start consumes the pending request
      if (core.phase == ST_IDLE && core.reportPending) begin
         next_core.reportPending = 1'b0;
         next_core.phase = ST_HEAD; // [R4]
         next_core.headIdx = 4'h0;
      end

      if (rxValid) begin
         if (rxData == CHAR_CR) begin // [R1]
            // exact four-letter word required [R3]
            if (core.rxCount == CMD_LEN && core.rxWord == SEND_REPORT_CMD) begin
               next_core.reportPending = 1'b1; // [R4]
            end else if (core.rxCount == CMD_LEN && core.rxWord == CLEAR_RECEIVE_CMD) begin
               next_core.clearSeen = 1'b1; // [R2]
            end else begin
               next_core.unknownSeen = 1'b1; // [R22]
            end
            next_core.rxWord = 32'h0; // [R2]
            next_core.rxCount = 3'h0;
         end else begin
            next_core.rxWord = {core.rxWord[23:0], rxData};
            if (core.rxCount != RX_COUNT_MAX) begin
               next_core.rxCount = core.rxCount + 3'h1;
            end
         end
      end

      if (genValid && genReady) begin
         case (core.phase)
            ST_HEAD: begin
               if (core.headIdx == HEAD_LEN - 4'h1) begin
                  next_core.phase = ST_FIELD;
                  next_core.fieldNum = FIRST_FIELD;
                  next_core.charIdx = 5'h0;
               end else begin
                  next_core.headIdx = core.headIdx + 4'h1;
               end
            end
            ST_FIELD: begin
               if (core.charIdx == fieldWidth - 5'h1) begin
                  next_core.charIdx = 5'h0;
                  if (core.fieldNum == LAST_FIELD) begin
                     next_core.phase = ST_ETX; // [R21]
                  end else begin
                     next_core.fieldNum = core.fieldNum + 7'h1; // [R20]
                  end
               end else begin
                  next_core.charIdx = core.charIdx + 5'h1;
               end
            end
            ST_ETX: begin
               next_core.phase = ST_CR;
            end
            ST_CR: begin
               next_core.phase = ST_IDLE;
            end
            default: begin
               next_core.phase = ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         core <= '{phase: ST_IDLE, default: '0};
      end else begin
         core <= next_core;
      end
   end

   // ------------------------------------------------------------
   // transmit buffer
   // ------------------------------------------------------------
   srcr_fifo #(
      .WIDTH(FIFO_WIDTH),
      .DEPTH(FIFO_DEPTH)
   ) txFifo (
      .mclk(mclk),
      .reset(reset),
      .inData(genByte),
      .inValid(genValid),
      .inReady(genReady),
      .outData(txData),
      .outValid(txValid),
      .outReady(txReady)
   );

   // ------------------------------------------------------------
   // status
   // ------------------------------------------------------------
   assign busy = (core.phase != ST_IDLE) || core.reportPending;
   assign clearSeen = core.clearSeen;
   assign unknownSeen = core.unknownSeen;

endmodule

/* verification/srcr_responder_assertions.sv */
// concurrent checks on the responder ports
`timescale 1ns/1ps
module srcr_responder_assertions
   import srcr_pkg::*;
(
   input wire logic mclk,
   input wire logic reset,
   input wire logic [7:0] rxData,
   input wire logic rxValid,
   input wire logic [7:0] txData,
   input wire logic txValid,
   input wire logic txReady,
   input wire logic busy,
   input wire logic clearSeen,
   input wire logic unknownSeen
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);
   // ----------------------------------------
   // sequences
   // ----------------------------------------
   sequence report_start;
      rxValid && rxData == CHAR_CR && !busy && !txValid ##1 busy;
   endsequence
   sequence etx_pop;
      txValid && txReady && txData == CHAR_ETX;
   endsequence
   // ----------------------------------------
   // properties
   // ----------------------------------------
   AST_HOLD_BYTE: assert property (txValid && !txReady |=> txValid && $stable(txData))
      else $error("byte changed before it was taken");
   AST_CLEAR_AFTER_CR: assert property (clearSeen |-> $past(rxValid) && $past(rxData) == CHAR_CR)
      else $error("clear pulse without carriage return");
   AST_UNKNOWN_AFTER_CR: assert property (unknownSeen |-> $past(rxValid) && $past(rxData) == CHAR_CR)
      else $error("unknown pulse without carriage return");
   AST_PULSE_ALONE: assert property (clearSeen |-> !unknownSeen ##1 !clearSeen)
      else $error("clear pulse too long or overlapping");
   AST_BUSY_CAUSE: assert property ($rose(busy) |-> $past(rxValid) && $past(rxData) == CHAR_CR)
      else $error("report started without carriage return");
   AST_FIRST_BYTE: assert property (report_start |-> ##2 txValid && txData == 8'h4D)
      else $error("report head missing");
   AST_QUIET_IDLE: assert property (!busy && !txValid |=> !txValid)
      else $error("byte sent with no report running");
   AST_END_CR: assert property (etx_pop |-> ##[1:4] (txValid && txData == CHAR_CR))
      else $error("end byte not followed by carriage return");
   AST_DONE_FLUSH: assert property ($fell(busy) |-> txValid)
      else $error("report ended with empty output");
endmodule
bind srcr_responder srcr_responder_assertions chk (.mclk(mclk), .reset(reset), .rxData(rxData),
   .rxValid(rxValid), .txData(txData), .txValid(txValid), .txReady(txReady), .busy(busy),
   .clearSeen(clearSeen), .unknownSeen(unknownSeen));

/* verification/srcr_host_model.sv */
// host computer model: sends command text, accepts report bytes
`timescale 1ns/1ps
module srcr_host_model (
   input wire logic mclk,
   input wire logic reset,
   input wire logic hold,
   input wire logic slow,
   output logic [7:0] rxData,
   output logic rxValid,
   output logic txReady
);
   integer seed = 32'hC1A5EE3A;
   initial begin
      rxData = 8'h00;
      rxValid = 1'b0;
      txReady = 1'b0;
   end
   // takes bytes promptly, with random stalls, or not at all
   always @(posedge mclk) begin
      txReady <= hold ? 1'b0 : (slow ? 1'($random(seed)) : 1'b1);
   end
   // one character per cycle, then line shows inverse of last value
   task automatic send_text(input logic [39:0] w, input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge mclk);
         rxData <= w[(n-1-i)*8+:8];
         rxValid <= 1'b1;
      end
      @(posedge mclk);
      rxData <= ~rxData;
      rxValid <= 1'b0;
   endtask
endmodule

/* verification/tb.sv */
// self-checking bench for the serial report command responder
`timescale 1ns/1ps
module tb;
   import srcr_pkg::*;
   logic mclk = 1'b0;
   logic reset = 1'b1;
   logic [7:0] rxData, txData;
   logic rxValid, txValid, txReady, busy, clearSeen, unknownSeen, flowRamp, fullOxygenOn;
   logic [TEXT_BITS-1:0] timeText;
   logic [UNIT_ID_BITS-1:0] unitIdText;
   logic [DATE_BITS-1:0] dateText;
   logic [1:0] ventMode;
   logic [NUM_SETTING*TEXT_BITS-1:0] settingText;
   logic [NUM_MONITOR*TEXT_BITS-1:0] monitorText;
   logic hold = 1'b0;
   logic slow = 1'b0;
   integer seed = 32'hC1A5EE3A;
   int mismatches = 0;
   int cmp_count = 0;
   int clrCnt = 0;
   int unkCnt = 0;
   int c0, u0;
   logic [7:0] expQ[$];
   logic [39:0] cmds[3] = '{{CLEAR_RECEIVE_CMD, CHAR_CR}, {SEND_ALT_REPORT_CMD, CHAR_CR}, 40'h515A58590D};
   localparam logic [39:0] REPORT_LINE = {SEND_REPORT_CMD, CHAR_CR};
   always #4 mclk = ~mclk;
   srcr_responder dut (.mclk(mclk), .reset(reset), .rxData(rxData), .rxValid(rxValid), .txData(txData),
      .txValid(txValid), .txReady(txReady), .timeText(timeText), .unitIdText(unitIdText),
      .dateText(dateText), .ventMode(ventMode), .flowRamp(flowRamp), .fullOxygenOn(fullOxygenOn),
      .settingText(settingText), .monitorText(monitorText), .busy(busy), .clearSeen(clearSeen),
      .unknownSeen(unknownSeen));
   srcr_host_model host (.mclk(mclk), .reset(reset), .hold(hold), .slow(slow), .rxData(rxData),
      .rxValid(rxValid), .txReady(txReady));
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic end_of_test();
      if (mismatches == 0 && cmp_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   function automatic logic [7:0] rnd_char();
      return {2'b01, 6'($random(seed))};
   endfunction
   // nul characters go out as spaces
   function automatic void push_text(input logic [143:0] t, input int n);
      for (int i = n - 1; i >= 0; i--) expQ.push_back(t[i*8+:8] === 8'h00 ? 8'h20 : t[i*8+:8]);
   endfunction
   function automatic void expect_report();
      push_text({REPORT_REPLY_CODE, BYTE_COUNT_TEXT, FIELD_COUNT_TEXT, CHAR_STX}, 11);
      for (int f = 5; f <= 99; f++) begin
         if (f == 5) push_text(timeText, 6);
         else if (f == 6) push_text(unitIdText, 18);
         else if (f == 8) push_text(dateText, 12);
         else if (f == 9) push_text(ventMode == 2'h0 ? TOKEN_ASSIST : ventMode == 2'h1 ? TOKEN_SYNC :
            ventMode == 2'h2 ? TOKEN_CONTINUOUS : TOKEN_TWO_LEVEL, 6);
         else if (f >= 10 && f <= 16) push_text(settingText[(f-10)*48+:48], 6);
         else if (f >= 21 && f <= 26) push_text(settingText[(f-14)*48+:48], 6);
         else if (f == 27) push_text(flowRamp ? "RAMP  " : "SQUARE", 6);
         else if (f == 30) push_text(fullOxygenOn ? "ON    " : "OFF   ", 6);
         else if (f >= 34 && f <= 42) push_text(monitorText[(f-34)*48+:48], 6);
         else if (f == 45 || f == 46) push_text(monitorText[(f-36)*48+:48], 6);
         else push_text("NA    ", 6);
      end
      push_text(16'h030D, 2);
   endfunction
   task automatic new_fields(input logic [1:0] k);
      @(posedge mclk);
      for (int b = 0; b < 78; b++) begin
         settingText[b*8+:8] <= rnd_char();
         if (b < 66) monitorText[b*8+:8] <= rnd_char();
         if (b < 18) unitIdText[b*8+:8] <= rnd_char();
         if (b < 12) dateText[b*8+:8] <= rnd_char();
         if (b < 6) timeText[b*8+:8] <= (b == 0) ? 8'h00 : rnd_char();
      end
      ventMode <= k;
      flowRamp <= k[0];
      fullOxygenOn <= k[1];
      @(posedge mclk);
   endtask
   task automatic drain();
      int n;
      n = 0;
      while ((expQ.size() != 0 || busy !== 1'b0 || txValid !== 1'b0) && n < 20000) begin
         @(negedge mclk);
         n++;
      end
      check(8'(n >= 20000), 8'h00, "report not drained");
   endtask
   // ----------------------------------------
   // monitors and sequence
   // ----------------------------------------
   always @(posedge mclk) begin
      if (clearSeen === 1'b1) clrCnt++;
      if (unknownSeen === 1'b1) unkCnt++;
      if (!reset && txValid === 1'b1 && txReady === 1'b1) begin
         if (expQ.size() == 0) check(txData, 8'hFF, "unexpected byte");
         else check(txData, expQ.pop_front(), "report byte");
      end
   end
   initial begin
      #400000;
      check(8'h01, 8'h00, "watchdog expired");
      end_of_test();
   end
   initial begin
      timeText = '0;
      unitIdText = '0;
      dateText = '0;
      ventMode = 2'h0;
      flowRamp = 1'b0;
      fullOxygenOn = 1'b0;
      settingText = '0;
      monitorText = '0;
      repeat (2) @(posedge mclk);
      reset <= 1'b0;
      @(negedge mclk);
      check(txValid, 1'b0, "valid after reset");
      check(busy, 1'b0, "busy after reset");
      host.send_text(40'(SEND_REPORT_CMD[31:8]), 3);
      repeat (8) @(negedge mclk);
      check(busy, 1'b0, "word without return");
      host.send_text(REPORT_LINE, 5);
      repeat (6) @(negedge mclk);
      check(busy, 1'b0, "overlong word");
      for (int i = 0; i < 3; i++) begin
         c0 = clrCnt;
         u0 = unkCnt;
         host.send_text(cmds[i], 5);
         repeat (3) @(negedge mclk);
         check(8'(clrCnt - c0), 8'(i == 0), "clear pulse");
         check(8'(unkCnt - u0), 8'(i != 0), "unknown pulse");
         check(busy, 1'b0, "no report");
      end
      for (int k = 0; k < 4; k++) begin
         new_fields(k[1:0]);
         slow <= k[0];
         hold <= (k == 2);
         expect_report();
         host.send_text(REPORT_LINE, 5);
         if (k == 3) begin
            host.send_text(REPORT_LINE, 5);
            expect_report();
            host.send_text({CLEAR_RECEIVE_CMD, CHAR_CR}, 5);
         end
         if (k == 2) begin
            repeat (60) @(posedge mclk);
            hold <= 1'b0;
         end
         drain();
      end
      end_of_test();
   end
endmodule
